// ### logic/fsg_guard.sv
// Functional notes
// - software write needs write enable, erase both
// - each lock bit covers one 8k block
// - lock bit zero blocks debug access type
// - scratchpad locked only when byte is zero
// - lock byte addresses depend on variant
// - software may write, not erase lock page
// - locked debug read returns undefined data
// - lock bytes always readable, writable to zero
// - lock page guarded by bit 7 or 3
// - unlocked lock page erasable, unlocks everything
// - locked: erase at lock byte means full erase
// - full erase only from debug port
// - limit address is register byte then 0x00
// - upper code cannot touch lower flash data
// - blocked code read returns 0x00
// - fetch and branch into lower stay allowed
// - lower code is unrestricted
// - limit register written once per reset
// - limit resets to zero, all readable
// - reserved area always blocked; the code blocks it only when VARIANT_32K is 0
// - lock bytes do not restrict firmware
// - reserved area is 0xFC00 to 0xFFFF
// - erase covers a 512-byte page
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

module fsg_guard
  import fsg_pkg::*;
#(
  parameter bit VARIANT_32K = 1'b0
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hsel,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire fsg_pkg::fsg_req_t req,
  input  wire logic [7:0]        flash_rdata,
  output fsg_pkg::fsg_resp_t     resp,
  output logic [7:0]             guard_rdata,
  output logic [7:0]             guard_wdata_mask
);
  import fsg_pkg::*;

  // only whole-word transfers reach the registers
  logic word_access;
  assign word_access = (hsize == 3'h2);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_lock_addr(input logic [15:0] a);
    logic [15:0] we_a;
    logic [15:0] rd_a;
    we_a = VARIANT_32K ? LOCK_WE_32K : LOCK_WE_64K;
    rd_a = VARIANT_32K ? LOCK_RD_32K : LOCK_RD_64K;
    is_lock_addr = (a == we_a) || (a == rd_a);
  endfunction

  function automatic logic is_lock_page(input logic [15:0] a);
    logic [15:0] we_a;
    we_a = VARIANT_32K ? LOCK_WE_32K : LOCK_WE_64K;
    is_lock_page = (a[15:PAGE_SHIFT] == we_a[15:PAGE_SHIFT]);
  endfunction

  function automatic logic block_open(input logic [7:0] lock, input logic [15:0] a,
                                      input logic scr);
    logic [2:0] blk;
    blk = a[15:BLOCK_SHIFT];
    if (scr)
      block_open = (lock != 8'h00);
    else if (VARIANT_32K && blk[2])
      block_open = 1'b1;
    else
      block_open = lock[blk];
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0]  ps_ctrl;
  logic [7:0]  limit;
  logic        limit_done;
  logic [7:0]  lock_we;
  logic [7:0]  lock_rd;
  logic [7:0]  deny_count;
  logic [7:0]  full_erase_count;

  logic        ph_valid;
  logic        ph_write;
  logic [7:0]  ph_addr;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ph_valid <= hsel && htrans[1] && word_access;
      ph_write <= hwrite;
      ph_addr  <= haddr[7:0];
    end
  end

  logic wr_en;
  assign wr_en = ph_valid && ph_write;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ps_ctrl <= PS_CTRL_RESET;
    else if (wr_en && ph_addr == ADDR_PS_CTRL)
      ps_ctrl <= hwdata[1:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      limit      <= LIMIT_RESET;
      limit_done <= 1'b0;
    end
    else if (wr_en && ph_addr == ADDR_LIMIT && !limit_done)
    begin
      limit      <= hwdata[7:0];
      limit_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // access decision
  // ---------------------------------------------------------------
  logic [15:0] limit_addr;
  assign limit_addr = {limit, LIMIT_LOW_BYTE};

  logic       lock_page_locked;
  logic [2:0] lock_blk;
  assign lock_blk = VARIANT_32K ? LOCK_BLK_32K : LOCK_BLK_64K;
  assign lock_page_locked = !lock_we[lock_blk];

  logic       in_reserved;
  logic       upper_code;
  logic       below_limit;
  logic       is_dbg;
  logic       grant;
  logic       full_erase;
  logic       blank;

  always_comb
  begin
    in_reserved = !VARIANT_32K && !req.scratch && (req.addr >= RESERVED_BASE);
    upper_code  = (req.pc >= limit_addr);
    below_limit = !req.scratch && (req.addr < limit_addr);
    is_dbg      = (req.src == FSG_SRC_DEBUG);
    grant       = 1'b0;
    full_erase  = 1'b0;
    blank       = 1'b0;
    if (in_reserved)
      grant = 1'b0;
    else if (is_dbg)
    begin
      case (req.op)
        FSG_OP_READ:
          if (!req.scratch && is_lock_addr(req.addr))
            grant = 1'b1;
          else
            grant = block_open(lock_rd, req.addr, req.scratch);
        FSG_OP_WRITE:
          if (!req.scratch && is_lock_addr(req.addr))
            grant = 1'b1;
          else
            grant = block_open(lock_we, req.addr, req.scratch);
        FSG_OP_ERASE:
          if (!req.scratch && is_lock_page(req.addr) && !lock_page_locked)
            grant = 1'b1;
          else if (!req.scratch && is_lock_addr(req.addr))
          begin
            grant      = 1'b1;
            full_erase = 1'b1;
          end
          else
            grant = block_open(lock_we, req.addr, req.scratch);
        default:
          grant = 1'b0;
      endcase
    end
    else
    begin
      // firmware: lock bytes ignored; enables, limit, lock page and read source apply
      if (upper_code && below_limit)
      begin
        grant = 1'b0;
        blank = (req.src == FSG_SRC_CODE_READ) && (req.op == FSG_OP_READ);
      end
      else
      begin
        case (req.op)
          FSG_OP_READ:  grant = (req.src == FSG_SRC_CODE_READ);
          FSG_OP_WRITE: grant = ps_ctrl[PS_WE_BIT];
          FSG_OP_ERASE:
            grant = ps_ctrl[PS_WE_BIT] && ps_ctrl[PS_EE_BIT]
                    && !(!req.scratch && is_lock_page(req.addr));
          default:      grant = 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // lock byte shadows, follow granted flash updates
  // ---------------------------------------------------------------
  logic [15:0] we_addr;
  logic [15:0] rd_addr;
  assign we_addr = VARIANT_32K ? LOCK_WE_32K : LOCK_WE_64K;
  assign rd_addr = VARIANT_32K ? LOCK_RD_32K : LOCK_RD_64K;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_we <= LOCK_ERASED;
      lock_rd <= LOCK_ERASED;
    end
    else if (req.valid && grant && req.op == FSG_OP_ERASE
             && (full_erase || (!req.scratch && is_lock_page(req.addr))))
    begin
      lock_we <= LOCK_ERASED;
      lock_rd <= LOCK_ERASED;
    end
    else if (req.valid && grant && req.op == FSG_OP_WRITE && !req.scratch)
    begin
      if (req.addr == we_addr)
        lock_we <= lock_we & flash_rdata;
      if (req.addr == rd_addr)
        lock_rd <= lock_rd & flash_rdata;
    end
  end

  // ---------------------------------------------------------------
  // verdict outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resp        <= '0;
      guard_rdata <= 8'h00;
    end
    else
    begin
      resp.valid      <= req.valid;
      resp.grant      <= req.valid && grant;
      resp.full_erase <= req.valid && full_erase;
      resp.blank_read <= req.valid && blank;
      guard_rdata     <= (grant) ? flash_rdata : DENIED_DATA;
    end
  end

  assign guard_wdata_mask = lock_we;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      deny_count       <= 8'h00;
      full_erase_count <= 8'h00;
    end
    else if (req.valid)
    begin
      if (!grant)
        deny_count <= deny_count + 8'h01;
      if (full_erase)
        full_erase_count <= full_erase_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite read mux
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite && word_access)
    begin
      case (haddr[7:0])
        ADDR_PS_CTRL: hrdata <= {30'h0, ps_ctrl};
        ADDR_LIMIT:   hrdata <= {23'h0, limit_done, limit};
        ADDR_LOCK_WE: hrdata <= {24'h0, lock_we};
        ADDR_LOCK_RD: hrdata <= {24'h0, lock_rd};
        ADDR_STATUS:  hrdata <= {16'h0, full_erase_count, deny_count};
        ADDR_VARIANT: hrdata <= {31'h0, VARIANT_32K};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

`default_nettype wire

// ### logic/fsg_pkg.sv
package fsg_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the ahb-lite slave)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PS_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LIMIT     = 8'h04;
  localparam logic [7:0] ADDR_LOCK_WE   = 8'h08;
  localparam logic [7:0] ADDR_LOCK_RD   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_VARIANT   = 8'h14;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         PS_WE_BIT      = 0;
  localparam int         PS_EE_BIT      = 1;
  localparam logic [1:0] PS_CTRL_RESET  = 2'h0;
  localparam logic [7:0] LIMIT_RESET    = 8'h00;
  localparam logic [7:0] LOCK_ERASED    = 8'hFF;
  localparam logic [7:0] DENIED_DATA    = 8'h00;
  localparam logic [7:0] LIMIT_LOW_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // flash geometry
  // ---------------------------------------------------------------
  localparam int          BLOCK_SHIFT   = 13;
  localparam int          PAGE_SHIFT    = 9;
  localparam logic [15:0] RESERVED_BASE = 16'hFC00;
  localparam logic [15:0] LOCK_WE_64K   = 16'hFBFE;
  localparam logic [15:0] LOCK_RD_64K   = 16'hFBFF;
  localparam logic [15:0] LOCK_WE_32K   = 16'h7FFE;
  localparam logic [15:0] LOCK_RD_32K   = 16'h7FFF;
  localparam logic [2:0]  LOCK_BLK_64K  = 3'h7;
  localparam logic [2:0]  LOCK_BLK_32K  = 3'h3;

  typedef enum logic [1:0] {
    FSG_OP_READ,
    FSG_OP_WRITE,
    FSG_OP_ERASE
  } fsg_op_t;

  typedef enum logic [1:0] {
    FSG_SRC_DEBUG,
    FSG_SRC_DATA_MOVE,
    FSG_SRC_CODE_READ
  } fsg_src_t;

  // one flash access request from either requester
  typedef struct packed {
    logic        valid;
    fsg_src_t    src;
    fsg_op_t     op;
    logic        scratch;
    logic [15:0] addr;
    logic [15:0] pc;
  } fsg_req_t;

  // verdict for the flash controller
  typedef struct packed {
    logic valid;
    logic grant;
    logic full_erase;
    logic blank_read;
  } fsg_resp_t;

endpackage

// ### tb/fsg_flash.sv
`timescale 1ns/10ps
`default_nettype none
module fsg_flash
  import fsg_pkg::*;
(
  input  wire logic     clk,
  input  wire fsg_req_t req,
  input  wire logic [7:0] wbyte,
  output logic [7:0]    flash_rdata
);
  logic [7:0] idle_cnt = 8'h00;
  // -------------------------------------------------
  // flash byte array as a pattern, busy bus when idle
  // -------------------------------------------------
  always @(posedge clk)
    idle_cnt <= idle_cnt + 8'h3B;
  always_comb
    if (!req.valid)
      flash_rdata = idle_cnt;
    else if (req.op == FSG_OP_WRITE)
      flash_rdata = wbyte;
    else
      flash_rdata = req.addr[7:0] ^ req.addr[15:8] ^ 8'h5A;
endmodule
`default_nettype wire

// ### tb/fsg_guard_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fsg_guard_chk
  import fsg_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire fsg_req_t  req,
  input  wire logic [7:0] flash_rdata,
  input  wire fsg_resp_t resp,
  input  wire logic [7:0] guard_rdata,
  input  wire logic [7:0] guard_wdata_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_fe_debug_only: assert property (resp.full_erase |->
    $past(req.valid && req.src == FSG_SRC_DEBUG)) else $error("full erase not from debug");
  a_fe_lock_addr: assert property (resp.full_erase |->
    $past(req.op == FSG_OP_ERASE && req.addr[15:1] == LOCK_WE_64K[15:1]))
    else $error("full erase off lock byte");
  a_reserved_deny: assert property ($past(req.valid && req.addr >= RESERVED_BASE) |->
    resp.valid && !resp.grant) else $error("reserved area granted");
  a_sw_lock_erase: assert property ($past(req.valid && req.src != FSG_SRC_DEBUG &&
    req.op == FSG_OP_ERASE && req.addr[15:9] == 7'h7D) |-> !resp.grant && !resp.full_erase)
    else $error("software erased lock page");
  a_blank_read: assert property (resp.valid && !resp.grant |->
    guard_rdata == DENIED_DATA) else $error("denied data not zero");
  a_blank_deny: assert property (resp.blank_read |->
    resp.valid && !resp.grant) else $error("blank read granted");
  a_grant_data: assert property (resp.grant && $past(req.op == FSG_OP_READ) |->
    guard_rdata == $past(flash_rdata)) else $error("granted data wrong");
  a_fw_read_ok: assert property ($past(req.valid && req.src == FSG_SRC_CODE_READ &&
    req.op == FSG_OP_READ && !req.scratch && req.pc <= req.addr &&
    req.addr < RESERVED_BASE) |-> resp.grant) else $error("firmware read denied");
  a_dbg_we_lock: assert property ($past(req.valid && req.src == FSG_SRC_DEBUG &&
    req.op != FSG_OP_READ && !req.scratch && req.addr < 16'hFA00 &&
    !guard_wdata_mask[req.addr[15:13]]) |-> !resp.grant) else $error("locked block altered");
  a_lock_rd_ok: assert property ($past(req.valid && req.src == FSG_SRC_DEBUG &&
    req.op == FSG_OP_READ && req.addr[15:1] == LOCK_WE_64K[15:1]) |-> resp.grant)
    else $error("lock byte read denied");
endmodule
bind fsg_guard fsg_guard_chk fsg_guard_chk_inst (.clk, .resetn, .req, .flash_rdata, .resp,
  .guard_rdata, .guard_wdata_mask);
`default_nettype wire

// ### tb/flash_security_access_guard_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module flash_security_access_guard_bench;
  import fsg_pkg::*;
  localparam fsg_src_t DB = FSG_SRC_DEBUG;
  localparam fsg_src_t DM = FSG_SRC_DATA_MOVE;
  localparam fsg_src_t CR = FSG_SRC_CODE_READ;
  localparam fsg_op_t  RD = FSG_OP_READ;
  localparam fsg_op_t  WR = FSG_OP_WRITE;
  localparam fsg_op_t  ER = FSG_OP_ERASE;
  logic        clk = 0, resetn = 0, hwrite, hready, hreadyout, hresp, g, cr;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0]  htrans;
  logic [7:0]  flash_rdata, guard_rdata, guard_wdata_mask, wbyte;
  logic [15:0] a, p;
  logic [15:0] ca [3] = '{16'h3FFF, 16'h0000, 16'h4000};
  logic [15:0] cp [3] = '{16'h4000, 16'h3FFF, 16'h4000};
  fsg_req_t    req;
  fsg_resp_t   resp;
  int          n_mismatch = 0, checked = 0, i;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  fsg_guard fsg_guard_inst (.clk, .resetn, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hsel(1'b1), .hready, .hrdata, .hreadyout, .hresp, .req, .flash_rdata, .resp,
    .guard_rdata, .guard_wdata_mask);
  fsg_flash fsg_flash_inst (.clk, .req, .wbyte, .flash_rdata);
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task wrap_up;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wt;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge clk);
    end
    if (k >= 20)
    begin
      n_mismatch++;
      wrap_up;
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, ad};
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task acc(input fsg_src_t s, input fsg_op_t o, input logic [15:0] ad, input logic [15:0] pc,
           input logic e);
    @(posedge clk);
    req <= '{1'b1, s, o, 1'b0, ad, pc};
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    `CHK(resp.grant, e)
  endtask
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial
  begin
    htrans = 0; haddr = 0; hwdata = 0; hwrite = 0; req = '0; wbyte = 0; seed = 32'h2844;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_LIMIT, 32'h0);
    rd(ADDR_PS_CTRL, 32'h0);
    rd(ADDR_LOCK_WE, 32'hFF);
    rd(8'h20, 32'h0);
    acc(DM, WR, 16'h2000, 16'h0100, 1'b0);
    wr(ADDR_PS_CTRL, 32'h1);
    acc(DM, WR, 16'h2000, 16'h0100, 1'b1);
    acc(DM, ER, 16'h2000, 16'h0100, 1'b0);
    wr(ADDR_PS_CTRL, 32'h3);
    acc(DM, ER, 16'h2000, 16'h0100, 1'b1);
    acc(DM, ER, 16'hFA10, 16'h0100, 1'b0);
    $display("test software enables done");
    wr(ADDR_LIMIT, 32'h40);
    wr(ADDR_LIMIT, 32'h80);
    rd(ADDR_LIMIT, 32'h140);
    for (i = 0; i < 27; i++)
    begin
      seed = xs(seed);
      a = i < 3 ? ca[i] : seed[15:0];
      p = i < 3 ? cp[i] : seed[31:16];
      cr = i < 3 || seed[7];
      g = cr && a < RESERVED_BASE && !(p >= 16'h4000 && a < 16'h4000);
      acc(cr ? CR : DM, RD, a, p, g);
      `CHK(guard_rdata, g ? (a[7:0] ^ a[15:8] ^ 8'h5A) : DENIED_DATA)
      `CHK(resp.blank_read, cr && p >= 16'h4000 && a < 16'h4000)
    end
    $display("test access limit done");
    wbyte = 8'hFE;
    acc(DB, WR, LOCK_WE_64K, 16'h0, 1'b1);
    `CHK(guard_wdata_mask, 8'hFE)
    acc(DB, WR, 16'h0100, 16'h0, 1'b0);
    acc(DB, WR, 16'h2000, 16'h0, 1'b1);
    wbyte = 8'hFD;
    acc(DB, WR, LOCK_RD_64K, 16'h0, 1'b1);
    acc(DB, RD, 16'h2100, 16'h0, 1'b0);
    acc(DB, RD, 16'h0100, 16'h0, 1'b1);
    acc(DB, RD, LOCK_WE_64K, 16'h0, 1'b1);
    acc(DB, RD, 16'hFC10, 16'h0, 1'b0);
    acc(CR, RD, 16'h0100, 16'h0, 1'b1);
    acc(DB, ER, 16'hFA00, 16'h0, 1'b1);
    rd(ADDR_LOCK_WE, 32'hFF);
    wbyte = 8'h7F;
    acc(DB, WR, LOCK_WE_64K, 16'h0, 1'b1);
    acc(DB, ER, 16'hFA00, 16'h0, 1'b0);
    acc(DM, ER, LOCK_WE_64K, 16'h0, 1'b0);
    `CHK(resp.full_erase, 1'b0)
    acc(DB, ER, LOCK_RD_64K, 16'h0, 1'b1);
    `CHK(resp.full_erase, 1'b1)
    rd(ADDR_LOCK_WE, 32'hFF);
    $display("test debug locks done");
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_LIMIT, 32'h0);
    wr(ADDR_LIMIT, 32'h80);
    rd(ADDR_LIMIT, 32'h180);
    acc(CR, RD, 16'h7F00, 16'h8000, 1'b0);
    acc(CR, RD, 16'h8000, 16'h8000, 1'b1);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_VARIANT, 32'h0);
    $display("test second reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
